// ### nacc_alu_decoder.sv
// accumulator operation decoder and executor with an AXI4-Lite register slave
// Operation
// [RULE_01] 16-bit image carries 10-bit word plus ones
// [RULE_02] and register nibble, carry A3 and bit3
// [RULE_03] and table high nibble, carry A3 and bit7
// [RULE_04] and table low nibble, carry A3 and bit3
// [RULE_05] and immediate, two words, carry A3 and bit3
// [RULE_06] or register nibble, carry cleared
// [RULE_07] or table high or low, carry cleared
// [RULE_08] or immediate, two words, carry cleared
// [RULE_09] xor register nibble, carry A3 and bit3
// [RULE_10] xor table nibble, carry A3 and ROM bit
// [RULE_11] xor immediate, carry A3 and bit3
// [RULE_12] increment modulo sixteen, carry on zero result
// [RULE_13] rotate left, bit3 to bit0 and carry
// [RULE_14] guarded rotate resets core on zero accumulator
// [RULE_15] one or two words, one instruction cycle
// [RULE_16] cycle is 16 or 8 us option
// [RULE_17] increment clears carry on nonzero result
// [RULE_18] guarded reset reinitialises core like system reset
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
module nacc_alu_decoder
   import nacc_pkg::*;
#(
   parameter bit HIGH_SPEED = 1'b0,
   parameter int ADDR_W = 8
) (
   // clock and reset
   input wire logic CLOCK,
   input wire logic ARST_N,
   // AXI4-Lite write address and data
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   // AXI4-Lite write response
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   // data memory operand
   output logic DATA_BANK,
   output logic [3:0] DATA_INDEX,
   input wire logic [3:0] DATA_NIBBLE,
   // program memory table operand
   output logic [7:0] ROM_ADDR,
   input wire logic [9:0] ROM_DATA,
   // core reset request
   output logic CORE_RESET
);
   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int INSTR_CYCLES = HIGH_SPEED ? FAST_CYCLES : NORMAL_CYCLES; // [RULE_16]
   localparam int CNT_W = $clog2(INSTR_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(INSTR_CYCLES - 1);

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_EXEC = 1'b1
   } nacc_state_type;

   // ****************************************************************
   // state
   // ****************************************************************
   nacc_state_type state;
   logic [CNT_W-1:0] cnt;
   logic [15:0] instr_img;
   logic [3:0] imm;
   logic [3:0] page;
   logic [3:0] pointer;
   nacc_acc_type core;
   nacc_dec_type dec;
   logic illegal;
   logic guard_hit;
   logic soft_rst;
   logic aw_full;
   logic [ADDR_W-1:0] aw_addr;
   logic w_full;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic new_two_word_q;

   // ****************************************************************
   // image recovery and decode of incoming write data
   // ****************************************************************
   wire [15:0] new_img = w_data[15:0];
   wire [9:0] nat = nacc_native(new_img); // [RULE_01]
   wire framed = (new_img[15:13] == EXT_PATTERN) && (new_img[7:5] == EXT_PATTERN); // [RULE_01]
   wire [5:0] rf = nat[9:4];
   // register forms carry a zero index in their reference images
   wire and_r0 = {rf, 4'h0} == nacc_native(IMG_AND_R0); // [RULE_02]
   wire and_r1 = {rf, 4'h0} == nacc_native(IMG_AND_R1); // [RULE_02]
   wire or_r0 = {rf, 4'h0} == nacc_native(IMG_OR_R0); // [RULE_06]
   wire or_r1 = {rf, 4'h0} == nacc_native(IMG_OR_R1); // [RULE_06]
   wire xor_r0 = {rf, 4'h0} == nacc_native(IMG_XOR_R0); // [RULE_09]
   wire xor_r1 = {rf, 4'h0} == nacc_native(IMG_XOR_R1); // [RULE_09]
   wire is_reg = and_r0 | and_r1 | or_r0 | or_r1 | xor_r0 | xor_r1;
   wire t_hi = (nat == nacc_native(IMG_AND_TH)) | (nat == nacc_native(IMG_OR_TH))
      | (nat == nacc_native(IMG_XOR_TH)); // [RULE_03] [RULE_07] [RULE_10]
   wire t_lo = (nat == nacc_native(IMG_AND_TL)) | (nat == nacc_native(IMG_OR_TL))
      | (nat == nacc_native(IMG_XOR_TL)); // [RULE_04] [RULE_07] [RULE_10]
   wire t_im = (nat == nacc_native(IMG_AND_IM)) | (nat == nacc_native(IMG_OR_IM))
      | (nat == nacc_native(IMG_XOR_IM)); // [RULE_05] [RULE_08] [RULE_11]
   wire k_and = and_r0 | and_r1 | (nat == nacc_native(IMG_AND_TH))
      | (nat == nacc_native(IMG_AND_TL)) | (nat == nacc_native(IMG_AND_IM));
   wire k_or = or_r0 | or_r1 | (nat == nacc_native(IMG_OR_TH))
      | (nat == nacc_native(IMG_OR_TL)) | (nat == nacc_native(IMG_OR_IM));
   wire k_xor = xor_r0 | xor_r1 | (nat == nacc_native(IMG_XOR_TH))
      | (nat == nacc_native(IMG_XOR_TL)) | (nat == nacc_native(IMG_XOR_IM));
   wire k_inc = nat == nacc_native(IMG_INC);
   wire k_rot = nat == nacc_native(IMG_ROT);
   wire k_grot = nat == nacc_native(IMG_GROT);
   wire nacc_kind_type new_kind = !framed ? OP_NONE : k_and ? OP_AND : k_or ? OP_OR
      : k_xor ? OP_XOR : k_inc ? OP_INC : k_rot ? OP_ROT : k_grot ? OP_GROT : OP_NONE;
   wire nacc_src_type new_src = t_hi ? SRC_TBL_HI : t_lo ? SRC_TBL_LO
      : t_im ? SRC_IMM : SRC_REG;
   wire new_bank1 = and_r1 | or_r1 | xor_r1;
   wire [3:0] new_index = is_reg ? nat[3:0] : 4'h0;
   wire nacc_dec_type new_dec = '{new_kind, new_src, new_bank1, new_index};
   // two-word forms fetch their second word from the immediate register
   wire new_two_word = framed & t_im; // [RULE_15]

   // ****************************************************************
   // AXI4-Lite write side
   // ****************************************************************
   wire aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
   wire w_take = S_AXI_WVALID & S_AXI_WREADY;
   wire wr_do = aw_full & w_full & ~S_AXI_BVALID;
   wire [7:0] wr_addr = 8'(aw_addr);
   wire wr_hit = (wr_addr == REG_INSTR) | (wr_addr == REG_IMM) | (wr_addr == REG_TABLE)
      | (wr_addr == REG_ACC) | (wr_addr == REG_STATUS) | (wr_addr == REG_NATIVE);
   wire lo_lane = w_strb[0];
   wire idle = state == ST_IDLE;
   wire wr_instr = wr_do & (wr_addr == REG_INSTR) & (&w_strb[1:0]) & idle;
   wire wr_imm = wr_do & (wr_addr == REG_IMM) & lo_lane;
   wire wr_table = wr_do & (wr_addr == REG_TABLE) & lo_lane;
   wire wr_acc = wr_do & (wr_addr == REG_ACC) & lo_lane & idle;
   wire wr_stat = wr_do & (wr_addr == REG_STATUS) & lo_lane;
   wire start = wr_instr & (new_kind != OP_NONE);
   wire bad_instr = wr_instr & (new_kind == OP_NONE); // [RULE_01]
   assign S_AXI_AWREADY = ~aw_full;
   assign S_AXI_WREADY = ~w_full;

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         aw_full <= 1'b0;
         aw_addr <= '0;
         w_full <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= RESP_OKAY;
      end else begin
         if (aw_take) begin
            aw_full <= 1'b1;
            aw_addr <= S_AXI_AWADDR;
         end else if (wr_do) begin
            aw_full <= 1'b0;
         end
         if (w_take) begin
            w_full <= 1'b1;
            w_data <= S_AXI_WDATA;
            w_strb <= S_AXI_WSTRB;
         end else if (wr_do) begin
            w_full <= 1'b0;
         end
         if (wr_do) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // AXI4-Lite read side
   // ****************************************************************
   wire rd_take = S_AXI_ARVALID & S_AXI_ARREADY;
   wire [7:0] rd_addr = 8'(S_AXI_ARADDR);
   wire [31:0] st_word = {29'h0, guard_hit, illegal, ~idle};
   wire [31:0] rd_word = (rd_addr == REG_INSTR) ? {16'h0000, instr_img}
      : (rd_addr == REG_IMM) ? {28'h0, imm}
      : (rd_addr == REG_TABLE) ? {24'h0, page, pointer}
      : (rd_addr == REG_ACC) ? {27'h0, core}
      : (rd_addr == REG_STATUS) ? st_word
      : (rd_addr == REG_NATIVE) ? {21'h0, new_two_word_q, nacc_native(instr_img)}
      : 32'h0000_0000;
   wire rd_hit = (rd_addr == REG_INSTR) | (rd_addr == REG_IMM) | (rd_addr == REG_TABLE)
      | (rd_addr == REG_ACC) | (rd_addr == REG_STATUS) | (rd_addr == REG_NATIVE);
   assign S_AXI_ARREADY = ~S_AXI_RVALID;

   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0000_0000;
         S_AXI_RRESP <= RESP_OKAY;
      end else if (rd_take) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RDATA <= rd_word;
         S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end

   // ****************************************************************
   // execution datapath
   // ****************************************************************
   wire fire = (state == ST_EXEC) && (cnt == CNT_LAST); // [RULE_15]
   wire [3:0] opnd = (dec.src == SRC_REG) ? DATA_NIBBLE // [RULE_02] [RULE_06] [RULE_09]
      : (dec.src == SRC_TBL_HI) ? ROM_DATA[7:4] // [RULE_03] [RULE_07] [RULE_10]
      : (dec.src == SRC_TBL_LO) ? ROM_DATA[3:0] // [RULE_04] [RULE_07] [RULE_10]
      : imm; // [RULE_05] [RULE_08] [RULE_11]
   wire and_carry = core.acc[3] & opnd[3];
   wire [3:0] inc_val = core.acc + 4'h1; // [RULE_12]
   wire [3:0] rot_val = {core.acc[2:0], core.acc[3]}; // [RULE_13]
   wire acc_zero = core.acc == 4'h0;
   wire guard_fire = fire & (dec.kind == OP_GROT) & acc_zero; // [RULE_14]
   nacc_acc_type next_core;

   always_comb begin
      next_core = core;
      unique case (dec.kind)
         OP_AND: next_core = '{and_carry, core.acc & opnd}; // [RULE_02] [RULE_03] [RULE_04]
         OP_OR: next_core = '{1'b0, core.acc | opnd}; // [RULE_06] [RULE_07] [RULE_08]
         OP_XOR: next_core = '{and_carry, core.acc ^ opnd}; // [RULE_09] [RULE_10] [RULE_11]
         OP_INC: next_core = '{inc_val == 4'h0, inc_val}; // [RULE_12] [RULE_17]
         OP_ROT: next_core = '{core.acc[3], rot_val}; // [RULE_13]
         OP_GROT: next_core = '{core.acc[3], rot_val}; // [RULE_14]
         OP_NONE: next_core = core;
      endcase
   end

   // ****************************************************************
   // sequencer and core state
   // ****************************************************************
   // the guarded reset is synchronous so it never races the async pin
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         state <= ST_IDLE;
         cnt <= '0;
         dec <= '{OP_NONE, SRC_REG, 1'b0, 4'h0};
         instr_img <= 16'h0000;
         new_two_word_q <= 1'b0;
         core <= '{1'b0, ACC_RESET};
         soft_rst <= 1'b0;
      end else begin
         soft_rst <= guard_fire; // [RULE_14]
         if (soft_rst) begin
            state <= ST_IDLE; // [RULE_18]
            cnt <= '0;
            core <= '{1'b0, ACC_RESET};
         end else if (start) begin
            state <= ST_EXEC;
            cnt <= '0;
            dec <= new_dec;
            instr_img <= new_img;
            new_two_word_q <= new_two_word;
         end else if (fire) begin
            state <= ST_IDLE;
            if (!guard_fire) begin
               core <= next_core;
            end
         end else begin
            if (state == ST_EXEC) begin
               cnt <= cnt + CNT_W'(1);
            end
            if (wr_acc) begin
               core <= '{w_data[CARRY_BIT], w_data[3:0]};
            end
         end
      end
   end

   // ****************************************************************
   // operand registers and sticky status
   // ****************************************************************
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         imm <= 4'h0;
         page <= 4'h0;
         pointer <= 4'h0;
         illegal <= 1'b0;
         guard_hit <= 1'b0;
      end else begin
         if (soft_rst) begin
            page <= 4'h0; // [RULE_18]
            pointer <= 4'h0;
         end else if (wr_table) begin
            page <= w_data[PAGE_LSB +: NIB_W];
            pointer <= w_data[3:0];
         end
         if (wr_imm) begin
            imm <= w_data[3:0];
         end
         // a new event wins over a clear in the same cycle
         illegal <= bad_instr | (illegal & ~(wr_stat & w_data[ST_ILLEGAL_BIT]));
         guard_hit <= guard_fire | (guard_hit & ~(wr_stat & w_data[ST_GUARD_BIT]));
      end
   end

   assign DATA_BANK = dec.bank1;
   assign DATA_INDEX = dec.index;
   assign ROM_ADDR = {page, pointer}; // [RULE_03]
   assign CORE_RESET = soft_rst; // [RULE_18]

   // ****************************************************************
   // checks
   // ****************************************************************
   logic [CNT_W-1:0] exec_age;
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         exec_age <= '0;
      end else begin
         exec_age <= start ? '0 : exec_age + CNT_W'(state == ST_EXEC);
      end
   end

   property p_frame;
      @(posedge CLOCK) disable iff (!ARST_N)
      wr_instr && !framed |=> illegal && state == ST_IDLE;
   endproperty
   a_frame: assert property (p_frame) else $error("bad image not flagged"); // [RULE_01]

   property p_and_reg;
      @(posedge CLOCK) disable iff (!ARST_N)
      fire && dec.kind == OP_AND && dec.src == SRC_REG |=>
         core.carry == ($past(core.acc[3]) & $past(DATA_NIBBLE[3]))
         && core.acc == ($past(core.acc) & $past(DATA_NIBBLE));
   endproperty
   a_and_reg: assert property (p_and_reg) else $error("and register wrong"); // [RULE_02]

   property p_and_hi;
      @(posedge CLOCK) disable iff (!ARST_N)
      fire && dec.kind == OP_AND && dec.src == SRC_TBL_HI |=>
         core.carry == ($past(core.acc[3]) & $past(ROM_DATA[7]));
   endproperty
   a_and_hi: assert property (p_and_hi) else $error("table high carry wrong"); // [RULE_03]

   property p_or_clear;
      @(posedge CLOCK) disable iff (!ARST_N)
      fire && dec.kind == OP_OR |=> !core.carry;
   endproperty
   a_or_clear: assert property (p_or_clear) else $error("or left carry set"); // [RULE_06]

   property p_xor_imm;
      @(posedge CLOCK) disable iff (!ARST_N)
      fire && dec.kind == OP_XOR && dec.src == SRC_IMM |=>
         core.acc == ($past(core.acc) ^ $past(imm));
   endproperty
   a_xor_imm: assert property (p_xor_imm) else $error("xor immediate wrong"); // [RULE_11]

   property p_inc;
      @(posedge CLOCK) disable iff (!ARST_N)
      fire && dec.kind == OP_INC |=> core.carry == (core.acc == 4'h0)
         && core.acc == 4'($past(core.acc) + 4'h1);
   endproperty
   a_inc: assert property (p_inc) else $error("increment wrong"); // [RULE_17]

   property p_rot;
      @(posedge CLOCK) disable iff (!ARST_N)
      fire && dec.kind == OP_ROT |=> core.carry == $past(core.acc[3])
         && core.acc[0] == $past(core.acc[3]);
   endproperty
   a_rot: assert property (p_rot) else $error("rotate wrong"); // [RULE_13]

   property p_guard;
      @(posedge CLOCK) disable iff (!ARST_N)
      fire && dec.kind == OP_GROT && core.acc == 4'h0 |=>
         CORE_RESET ##1 (!CORE_RESET && core.acc == ACC_RESET && state == ST_IDLE);
   endproperty
   a_guard: assert property (p_guard) else $error("guarded reset missing"); // [RULE_14]

   property p_time;
      @(posedge CLOCK) disable iff (!ARST_N)
      fire |-> exec_age == CNT_LAST;
   endproperty
   a_time: assert property (p_time) else $error("instruction cycle length off"); // [RULE_16]
endmodule // nacc_alu_decoder

// ### nacc_pkg.sv
// constants, types and helpers of the nibble accumulator ALU decoder
package nacc_pkg;
   // ****************************************************************
   // register map, byte addresses
   // ****************************************************************
   localparam logic [7:0] REG_INSTR = 8'h00;
   localparam logic [7:0] REG_IMM = 8'h04;
   localparam logic [7:0] REG_TABLE = 8'h08;
   localparam logic [7:0] REG_ACC = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_NATIVE = 8'h14;
   // ****************************************************************
   // field layouts
   // ****************************************************************
   localparam int NIB_W = 4;
   localparam int IMG_W = 16;
   localparam int NAT_W = 10;
   localparam int CARRY_BIT = 4;
   localparam int PAGE_LSB = 4;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_ILLEGAL_BIT = 1;
   localparam int ST_GUARD_BIT = 2;
   localparam int NAT_LEN_BIT = 10;
   localparam logic [2:0] EXT_PATTERN = 3'b111;
   localparam logic [3:0] ACC_RESET = 4'h0;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_FREQ_MHZ = 125;
   localparam int OSC_FREQ_MHZ = 4;
   localparam int NORMAL_TIME_NS = 16000;
   localparam int FAST_TIME_NS = 8000;
   localparam int NORMAL_OSC_PERIODS = NORMAL_TIME_NS * OSC_FREQ_MHZ / 1000;
   localparam int FAST_OSC_PERIODS = FAST_TIME_NS * OSC_FREQ_MHZ / 1000;
   localparam int NORMAL_CYCLES = (NORMAL_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int FAST_CYCLES = (FAST_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
   // ****************************************************************
   // instruction images as the assembler emits them
   // ****************************************************************
   localparam logic [15:0] IMG_AND_R0 = 16'hFBE0;
   localparam logic [15:0] IMG_AND_R1 = 16'hFAE0;
   localparam logic [15:0] IMG_AND_TH = 16'hFAF0;
   localparam logic [15:0] IMG_AND_TL = 16'hFBF0;
   localparam logic [15:0] IMG_AND_IM = 16'hFBF1;
   localparam logic [15:0] IMG_OR_R0 = 16'hFDE0;
   localparam logic [15:0] IMG_OR_R1 = 16'hFCE0;
   localparam logic [15:0] IMG_OR_TH = 16'hFCF0;
   localparam logic [15:0] IMG_OR_TL = 16'hFDF0;
   localparam logic [15:0] IMG_OR_IM = 16'hFDF1;
   localparam logic [15:0] IMG_XOR_R0 = 16'hF5E0;
   localparam logic [15:0] IMG_XOR_R1 = 16'hF4E0;
   localparam logic [15:0] IMG_XOR_TH = 16'hF4F0;
   localparam logic [15:0] IMG_XOR_TL = 16'hF5F0;
   localparam logic [15:0] IMG_XOR_IM = 16'hF5F1;
   localparam logic [15:0] IMG_INC = 16'hF4F3;
   localparam logic [15:0] IMG_ROT = 16'hFCF3;
   localparam logic [15:0] IMG_GROT = 16'hFEF3;

   // drops the two inserted ones patterns
   function automatic logic [9:0] nacc_native(input logic [15:0] img);
      return {img[12:8], img[4:0]};
   endfunction

   typedef enum logic [2:0] {
      OP_NONE = 3'b000,
      OP_AND = 3'b001,
      OP_OR = 3'b011,
      OP_XOR = 3'b010,
      OP_INC = 3'b110,
      OP_ROT = 3'b111,
      OP_GROT = 3'b101
   } nacc_kind_type;

   typedef enum logic [1:0] {
      SRC_REG = 2'b00,
      SRC_TBL_HI = 2'b01,
      SRC_TBL_LO = 2'b11,
      SRC_IMM = 2'b10
   } nacc_src_type;

   typedef struct packed {
      nacc_kind_type kind;
      nacc_src_type src;
      logic bank1;
      logic [3:0] index;
   } nacc_dec_type;

   typedef struct packed {
      logic carry;
      logic [3:0] acc;
   } nacc_acc_type;
endpackage

// ### nibble_accumulator_alu_decoder_tb_top.sv
// self-checking testbench of the nibble accumulator ALU decoder
`timescale 1ns/1ps
module nibble_accumulator_alu_decoder_tb_top;
   import nacc_pkg::*;
   // ****************************************************************
   // wiring
   // ****************************************************************
   logic clk = 1'b0, arst_n = 1'b0;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0, rom_addr;
   logic [31:0] wdata = 32'h0, rdata, rd_v;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, bank, core_rst;
   logic [1:0] bresp, rresp, rsp;
   logic [3:0] dnib = 4'h0, index;
   logic [9:0] rom = 10'h0;
   int fails = 0, n_checks = 0, cyc = 0;
   always #4 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   nacc_alu_decoder #(.HIGH_SPEED(1'b1), .ADDR_W(8)) i_dut (
      .CLOCK(clk), .ARST_N(arst_n),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
      .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .DATA_BANK(bank), .DATA_INDEX(index), .DATA_NIBBLE(dnib),
      .ROM_ADDR(rom_addr), .ROM_DATA(rom), .CORE_RESET(core_rst));
   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] want);
      n_checks++;
      if (seen !== want) begin
         fails++;
         $display("wrong value %s expected %h seen %h", name, want, seen);
      end
   endtask
   // handshakes judged at the falling edge, where nothing is moving
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ha, hw, hb;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge clk);
         ha = awvalid && awready;
         hw = wvalid && wready;
         hb = bvalid;
         rsp = bresp;
         @(posedge clk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
      end while (!hb);
      // bready stays up, so a following call never drives it twice in one step
   endtask
   task automatic rd(input logic [7:0] a);
      logic hr, hv;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge clk);
         hr = arvalid && arready;
         hv = rvalid;
         rd_v = rdata;
         rsp = rresp;
         @(posedge clk);
         if (hr) arvalid <= 1'b0;
      end while (!hv);
   endtask
   // poke tries an accumulator write while busy, which must be dropped
   task automatic exec(input logic [15:0] img, input logic [3:0] imm, input logic poke);
      int t0;
      wr(REG_IMM, {28'h0, imm});
      wr(REG_INSTR, {16'h0, img});
      t0 = cyc;
      if (poke) wr(REG_ACC, 32'h0000_0007);
      do rd(REG_STATUS); while (rd_v[ST_BUSY_BIT] !== 1'b0);
      chk("cycles", 32'(cyc - t0 > FAST_CYCLES - 5 && cyc - t0 < FAST_CYCLES + 7), 32'h1);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_reset;
      rd(REG_ACC);
      chk("acc_rst", rd_v, 32'h0);
      rd(REG_STATUS);
      chk("status_rst", rd_v, 32'h0);
      chk("pins_rst", 32'({bank, index, rom_addr, core_rst}), 32'h0);
   endtask
   task automatic t_bus;
      wr(8'h40, 32'h0000_000F);
      chk("wr_resp", 32'(rsp), 32'(RESP_SLVERR));
      rd(8'h40);
      chk("rd_resp", 32'(rsp), 32'(RESP_SLVERR));
      wr(REG_INSTR, 32'h0000_1234);
      rd(REG_STATUS);
      chk("illegal", rd_v, 32'h0000_0002);
      wr(REG_STATUS, 32'h0000_0002);
      rd(REG_STATUS);
      chk("w1c", rd_v, 32'h0);
   endtask
   task automatic t_logic;
      logic [15:0] imgs [15] = '{IMG_AND_R0, IMG_AND_R1, IMG_AND_TH, IMG_AND_TL, IMG_AND_IM,
         IMG_OR_R0, IMG_OR_R1, IMG_OR_TH, IMG_OR_TL, IMG_OR_IM,
         IMG_XOR_R0, IMG_XOR_R1, IMG_XOR_TH, IMG_XOR_TL, IMG_XOR_IM};
      logic [15:0] img;
      logic [3:0] a, o;
      logic cy;
      dnib <= 4'h9;
      rom <= 10'h35E;
      wr(REG_TABLE, 32'h0000_00A5);
      chk("rom_addr", 32'(rom_addr), 32'h0000_00A5);
      for (int i = 0; i < 15; i++) begin
         img = imgs[i];
         if (img[7:4] == 4'hE) img = img | 16'(i);
         a = 4'hF ^ 4'(i);
         wr(REG_ACC, {27'h0, 1'b1, a});
         exec(img, 4'hB, 1'b0);
         o = img[7:4] == 4'hE ? 4'h9 : img[0] ? 4'hB : img[8] ? 4'hE : 4'h5;
         cy = a[3] & o[3];
         rd(REG_ACC);
         if (img[11:9] == 3'b101)
            chk("and", rd_v, {27'h0, cy, a & o});
         else if (img[11:9] == 3'b110)
            chk("or", rd_v, {27'h0, 1'b0, a | o});
         else
            chk("xor", rd_v, {27'h0, cy, a ^ o});
         if (img[7:4] == 4'hE)
            chk("operand", 32'({bank, index}), 32'({~img[8], img[3:0]}));
         rd(REG_NATIVE);
         chk("native", rd_v, {21'h0, img[7:0] == 8'hF1, img[12:8], img[4:0]});
      end
   endtask
   task automatic t_single;
      logic [15:0] img [4] = '{IMG_INC, IMG_INC, IMG_ROT, IMG_GROT};
      logic [3:0] ain [4] = '{4'hF, 4'h3, 4'hA, 4'h6};
      logic [4:0] want [4] = '{5'h10, 5'h04, 5'h15, 5'h0C};
      for (int i = 0; i < 4; i++) begin
         wr(REG_ACC, {27'h0, 1'b1, ain[i]});
         exec(img[i], 4'h0, i == 1);
         rd(REG_ACC);
         chk("single", rd_v, 32'(want[i]));
      end
   endtask
   task automatic t_guard;
      int n;
      wr(REG_ACC, 32'h0000_0010);
      wr(REG_INSTR, {16'h0, IMG_GROT});
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (core_rst !== 1'b1 && n < 1100);
      chk("pulse_at", 32'(n > FAST_CYCLES - 10 && n < FAST_CYCLES + 3), 32'h1);
      @(negedge clk);
      chk("pulse_len", 32'(core_rst), 32'h0);
      @(posedge clk);
      rd(REG_ACC);
      chk("acc_clr", rd_v, 32'h0);
      chk("table_clr", 32'(rom_addr), 32'h0);
      rd(REG_STATUS);
      chk("guard", rd_v, 32'h0000_0004);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1'b1;
      @(posedge clk);
      t_reset;
      t_bus;
      t_logic;
      t_single;
      t_guard;
      report_and_stop;
   end
   // twenty instructions of about a thousand cycles each
   initial begin
      repeat (40000) @(posedge clk);
      fails++;
      report_and_stop;
   end
endmodule // nibble_accumulator_alu_decoder_tb_top
